// [src/dedicated_protocol_framer.sv]
// Purpose: Host-side framer for the ASCII dedicated link protocol
// Assumes: Byte-wide UART on TX/RX ports, 50 MHz clock
// Notes:   Sends enquiry, answer and clear frames; parses replies
`timescale 1ns/1ps
`default_nettype none
`include "dp_framer_map.svh"

// Notes on behaviour
// - Control codes single bytes, fields ASCII
// - Format three: GG acknowledge, NN refusal
// - Block number two hex chars, reference only
// - Station field is always 00
// - Target CPU two hex chars, 00 to 40
// - Own rack addressed as CPU FF
// - Network master via local station: 00
// - Command is exactly two ASCII chars
// - Wait one hex char, 10 ms steps
// - Sum low byte, two hex, high first
// - Sum present only with checksum switch on
// - Sum spans station through character area
// - Format two adds block number after lead
// - Format three wraps frame in STX/ETX
// - Format four ends frames with CR LF
module dedicated_protocol_framer
  import dp_framer_pkg::*;
#(
  parameter int unsigned RESP_TIMEOUT_CYC = `RESP_TIMEOUT_CYC,
  parameter int unsigned FIFO_DEPTH       = 16,
  parameter int unsigned LEN_W            = 8
) (
  input  wire logic             REF_CLK_I,
  input  wire logic             SRST_I,
  input  wire logic [1:0]       FORMAT_I,
  input  wire logic             SUMCHK_EN_I,
  input  wire logic [7:0]       BLOCK_NO_I,
  input  wire logic [7:0]       TARGET_CPU_I,
  input  wire logic [15:0]      CMD_I,
  input  wire logic [3:0]       WAIT_I,
  input  wire logic [LEN_W-1:0] AREA_LEN_I,
  input  wire logic             REQ_I,
  input  wire logic             CLEAR_I,
  input  wire logic [7:0]       AREA_DATA_I,
  input  wire logic             AREA_VALID_I,
  output logic                  AREA_READY_O,
  output logic      [7:0]       TX_DATA_O,
  output logic                  TX_VALID_O,
  input  wire logic             TX_READY_I,
  input  wire logic [7:0]       RX_DATA_I,
  input  wire logic             RX_VALID_I,
  output logic      [7:0]       RD_DATA_O,
  output logic                  RD_VALID_O,
  output logic                  BUSY_O,
  output logic                  DONE_O,
  output logic      [2:0]       RESULT_O,
  output logic      [7:0]       ERR_CODE_O
);
  localparam int unsigned TW = $clog2(RESP_TIMEOUT_CYC + 1);

  tx_state_t        tx_st_q, tx_st_d;
  frame_kind_t      kind_q, kind_d;
  fmt_t             fmt_q, fmt_d;
  result_t          res_q, res_d;
  logic [3:0]       step_q, step_d, wait_q, wait_d;
  logic             cks_q, cks_d, busy_q, busy_d, done_q, done_d;
  logic             txv_q, txv_d;
  logic [7:0]       blk_q, blk_d, cpu_q, cpu_d, sum_q, sum_d;
  logic [7:0]       txd_q, txd_d, err_q, err_d;
  logic [15:0]      cmd_q, cmd_d;
  logic [LEN_W-1:0] left_q, left_d;
  logic [TW-1:0]    tmo_q, tmo_d;
  logic             slot, hused, hsum, tused;
  logic [7:0]       hbyte, tbyte;
  logic [7:0]       f_data;
  logic             f_valid, f_ready;

  rx_state_t        rx_st_q, rx_st_d;
  frame_kind_t      rkind_q, rkind_d;
  logic [2:0]       rcnt_q, rcnt_d;
  logic [7:0]       rsum_q, rsum_d, rerr_q, rerr_d, rdd_q, rdd_d;
  logic [3:0]       rnib_q, rnib_d;
  logic             rbad_q, rbad_d, rdv_q, rdv_d, rend_q, rend_d;
  logic             take;

  dp_area_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_area_fifo (
    .clk_i       (REF_CLK_I),
    .srst_i      (SRST_I),
    .in_data_i   (AREA_DATA_I),
    .in_valid_i  (AREA_VALID_I),
    .in_ready_o  (AREA_READY_O),
    .out_data_o  (f_data),
    .out_valid_o (f_valid),
    .out_ready_i (f_ready)
  );

  // Terminator bytes still due after the body of a reply
  function automatic logic [2:0] term_len(input fmt_t f, input frame_kind_t k);
    if (f == FMT4) begin
      term_len = 3'h2;
    end else if (f == FMT3 && k != K_DATA) begin
      term_len = 3'h1;
    end else begin
      term_len = 3'h0;
    end
  endfunction : term_len

  // Header and tail byte for the current step; unused steps are skipped
  always_comb begin
    hbyte = 8'h00;
    hused = 1'b1;
    hsum  = (step_q >= 4'h3) && (kind_q == K_ENQ);
    unique case (step_q)
      4'h0: begin
        if (fmt_q == FMT3) begin
          hbyte = `STX_CODE;
        end else begin
          unique case (kind_q)
            K_ACK:   hbyte = `ACK_CODE;
            K_NAK:   hbyte = `NAK_CODE;
            K_CLR:   hbyte = `EOT_CODE;
            default: hbyte = `ENQ_CODE;
          endcase
        end
      end
      4'h1: begin
        hbyte = hex_char(blk_q[7:4]);
        hused = (fmt_q == FMT2);
      end
      4'h2: begin
        hbyte = hex_char(blk_q[3:0]);
        hused = (fmt_q == FMT2);
      end
      4'h3: hbyte = hex_char(4'(`STATION_NUMBER >> 4));
      4'h4: hbyte = hex_char(4'(`STATION_NUMBER));
      4'h5: hbyte = hex_char(cpu_q[7:4]);
      4'h6: hbyte = hex_char(cpu_q[3:0]);
      4'h7: begin
        hused = (kind_q == K_ENQ) || (fmt_q == FMT3);
        unique case (kind_q)
          K_ACK:   hbyte = `GOOD_CODE;
          K_NAK:   hbyte = `NO_GOOD_CODE;
          K_CLR:   hbyte = `CLEAR_SEQ_CODE;
          default: hbyte = cmd_q[15:8];
        endcase
      end
      4'h8: begin
        hused = (kind_q == K_ENQ) || (fmt_q == FMT3 && kind_q != K_CLR);
        unique case (kind_q)
          K_ACK:   hbyte = `GOOD_CODE;
          K_NAK:   hbyte = `NO_GOOD_CODE;
          default: hbyte = cmd_q[7:0];
        endcase
      end
      default: begin
        hbyte = hex_char(wait_q);
        hused = (kind_q == K_ENQ);
      end
    endcase
    tbyte = 8'h00;
    tused = 1'b1;
    unique case (step_q)
      4'h0: begin
        tbyte = `ETX_CODE;
        tused = (fmt_q == FMT3);
      end
      4'h1: begin
        tbyte = hex_char(sum_q[7:4]);
        tused = cks_q && (kind_q == K_ENQ);
      end
      4'h2: begin
        tbyte = hex_char(sum_q[3:0]);
        tused = cks_q && (kind_q == K_ENQ);
      end
      4'h3: begin
        tbyte = `CR_CODE;
        tused = (fmt_q == FMT4);
      end
      default: begin
        tbyte = `LF_CODE;
        tused = (fmt_q == FMT4);
      end
    endcase
  end

  // Transmit sequencer; one output byte slot, refilled as the UART takes it
  always_comb begin
    tx_st_d = tx_st_q;
    kind_d  = kind_q;
    fmt_d   = fmt_q;
    cks_d   = cks_q;
    blk_d   = blk_q;
    cpu_d   = cpu_q;
    cmd_d   = cmd_q;
    wait_d  = wait_q;
    left_d  = left_q;
    step_d  = step_q;
    sum_d   = sum_q;
    res_d   = res_q;
    err_d   = err_q;
    tmo_d   = tmo_q;
    txd_d   = txd_q;
    txv_d   = txv_q && !TX_READY_I;
    done_d  = 1'b0;
    f_ready = 1'b0;
    slot    = !txv_q || TX_READY_I;
    unique case (tx_st_q)
      T_IDLE: begin
        if (CLEAR_I || REQ_I) begin
          fmt_d   = fmt_t'(FORMAT_I);
          cks_d   = SUMCHK_EN_I;
          blk_d   = BLOCK_NO_I;
          cpu_d   = TARGET_CPU_I;  // FF own rack, 00 master
          cmd_d   = CMD_I;
          wait_d  = WAIT_I;
          left_d  = AREA_LEN_I;
          sum_d   = 8'h00;
          step_d  = 4'h0;
          tx_st_d = T_HEAD;
          kind_d  = CLEAR_I ? K_CLR : K_ENQ;
          res_d   = CLEAR_I ? RES_CLEARED : RES_OK;
        end
      end
      T_HEAD: begin
        if (!hused || slot) begin
          if (hused) begin
            txd_d = hbyte;
            txv_d = 1'b1;
            if (hsum) begin
              sum_d = 8'(sum_q + hbyte);
            end
          end
          if (step_q == `HEAD_LAST_STEP) begin
            step_d  = 4'h0;
            tx_st_d = (kind_q == K_ENQ && left_q != '0) ? T_AREA : T_TAIL;
          end else begin
            step_d = step_q + 4'h1;
          end
        end
      end
      T_AREA: begin
        // Area bytes pass unchanged, same in every format
        f_ready = slot;
        if (slot && f_valid) begin
          txd_d  = f_data;
          txv_d  = 1'b1;
          sum_d  = 8'(sum_q + f_data);
          left_d = LEN_W'(left_q - 1'b1);
          if (left_q == LEN_W'(1)) begin
            tx_st_d = T_TAIL;
          end
        end
      end
      T_TAIL: begin
        if (step_q > `TAIL_LAST_STEP) begin
          // Frame ends only once its last byte has left the slot
          if (slot) begin
            step_d = 4'h0;
            if (kind_q == K_ENQ) begin
              // Reply waits for wait time and scan end
              tx_st_d = T_WAITRX;
              tmo_d   = TW'(RESP_TIMEOUT_CYC);
            end else begin
              tx_st_d = T_IDLE;
              done_d  = 1'b1;
            end
          end
        end else if (!tused || slot) begin
          if (tused) begin
            txd_d = tbyte;
            txv_d = 1'b1;
          end
          step_d = step_q + 4'h1;
        end
      end
      T_WAITRX: begin
        tmo_d = TW'(tmo_q - 1'b1);
        if (rend_q) begin
          unique case (rkind_q)
            K_DATA: begin
              // Answer data with acknowledge, or refuse a corrupt reply
              kind_d  = rbad_q ? K_NAK : K_ACK;
              res_d   = rbad_q ? RES_SUMERR : RES_OK;
              tx_st_d = T_HEAD;
            end
            K_NAK: begin
              res_d   = RES_NAK;
              err_d   = rerr_q;
              tx_st_d = T_IDLE;
              done_d  = 1'b1;
            end
            default: begin
              res_d   = RES_OK;
              tx_st_d = T_IDLE;
              done_d  = 1'b1;
            end
          endcase
        end else if (tmo_q == '0) begin
          // Silent device: clear its sequence before giving up
          kind_d  = K_CLR;
          res_d   = RES_TIMEOUT;
          tx_st_d = T_HEAD;
        end
      end
    endcase
    busy_d = (tx_st_d != T_IDLE);
  end

  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      tx_st_q <= T_IDLE;
      kind_q  <= K_ENQ;
      fmt_q   <= FMT1;
      cks_q   <= 1'b0;
      blk_q   <= 8'h00;
      cpu_q   <= 8'h00;
      cmd_q   <= 16'h0000;
      wait_q  <= 4'h0;
      left_q  <= '0;
      step_q  <= 4'h0;
      sum_q   <= 8'h00;
      res_q   <= RES_OK;
      err_q   <= 8'h00;
      tmo_q   <= '0;
      txd_q   <= 8'h00;
      txv_q   <= 1'b0;
      done_q  <= 1'b0;
      busy_q  <= 1'b0;
    end else begin
      tx_st_q <= tx_st_d;
      kind_q  <= kind_d;
      fmt_q   <= fmt_d;
      cks_q   <= cks_d;
      blk_q   <= blk_d;
      cpu_q   <= cpu_d;
      cmd_q   <= cmd_d;
      wait_q  <= wait_d;
      left_q  <= left_d;
      step_q  <= step_d;
      sum_q   <= sum_d;
      res_q   <= res_d;
      err_q   <= err_d;
      tmo_q   <= tmo_d;
      txd_q   <= txd_d;
      txv_q   <= txv_d;
      done_q  <= done_d;
      busy_q  <= busy_d;
    end
  end

  // Reply parser; bytes outside a wait are ignored, nulls always dropped
  always_comb begin
    take    = RX_VALID_I && (RX_DATA_I != `NUL_CODE)
              && (tx_st_q == T_WAITRX);
    rx_st_d = rx_st_q;
    rkind_d = rkind_q;
    rcnt_d  = rcnt_q;
    rsum_d  = rsum_q;
    rerr_d  = rerr_q;
    rnib_d  = rnib_q;
    rbad_d  = rbad_q;
    rdd_d   = rdd_q;
    rdv_d   = 1'b0;
    rend_d  = 1'b0;
    if (tx_st_q != T_WAITRX) begin
      rx_st_d = R_LEAD;
    end else begin
      unique case (rx_st_q)
        R_LEAD: begin
          if (take && (RX_DATA_I == `STX_CODE ||
              (fmt_q != FMT3 && (RX_DATA_I == `ACK_CODE ||
                                 RX_DATA_I == `NAK_CODE)))) begin
            rkind_d = (RX_DATA_I == `STX_CODE) ? K_DATA :
                      (RX_DATA_I == `ACK_CODE) ? K_ACK : K_NAK;
            rcnt_d  = (fmt_q == FMT2) ? 3'h6 : 3'h4;
            rsum_d  = 8'h00;
            rbad_d  = 1'b0;
            rerr_d  = 8'h00;
            rx_st_d = R_HEAD;
          end
        end
        R_HEAD: begin
          if (take) begin
            if (rcnt_q <= 3'h4) begin
              rsum_d = 8'(rsum_q + RX_DATA_I);
            end
            rcnt_d = rcnt_q - 3'h1;
            if (rcnt_q == 3'h1) begin
              unique case (rkind_q)
                K_ACK: begin
                  rx_st_d = R_TERM;
                  rcnt_d  = term_len(fmt_q, K_ACK);
                end
                K_NAK: begin
                  rx_st_d = R_ERR;
                  rcnt_d  = 3'h2;
                end
                default: rx_st_d = R_BODY;
              endcase
            end
          end
        end
        R_BODY: begin
          if (take) begin
            if (fmt_q == FMT3 && RX_DATA_I == `GOOD_CODE) begin
              rkind_d = K_ACK;
              rx_st_d = R_TERM;
              rcnt_d  = 3'h1 + term_len(fmt_q, K_ACK);
            end else if (fmt_q == FMT3 && RX_DATA_I == `NO_GOOD_CODE) begin
              rkind_d = K_NAK;
              rx_st_d = R_ERR;
              rcnt_d  = 3'h3;
            end else if (RX_DATA_I == `ETX_CODE) begin
              rx_st_d = cks_q ? R_SUM : R_TERM;
              rcnt_d  = cks_q ? 3'h2 : term_len(fmt_q, K_DATA);
            end else begin
              rdd_d  = RX_DATA_I;
              rdv_d  = 1'b1;
              rsum_d = 8'(rsum_q + RX_DATA_I);
            end
          end
        end
        R_ERR, R_SUM: begin
          if (take) begin
            if (rcnt_q == 3'h3) begin
              rcnt_d = 3'h2;  // Second N of the pair
            end else begin
              rnib_d = hex_val(RX_DATA_I);
              rbad_d = rbad_q || !hex_ok(RX_DATA_I);
              rcnt_d = rcnt_q - 3'h1;
              if (rcnt_q == 3'h1) begin
                if (rx_st_q == R_ERR) begin
                  rerr_d = {rnib_q, hex_val(RX_DATA_I)};
                end else if ({rnib_q, hex_val(RX_DATA_I)} != rsum_q) begin
                  rbad_d = 1'b1;
                end
                rx_st_d = R_TERM;
                rcnt_d  = term_len(fmt_q, rkind_q);
              end
            end
          end
        end
        default: begin
          // Terminators are counted, not checked
          if (rcnt_q == 3'h0) begin
            rend_d  = 1'b1;
            rx_st_d = R_LEAD;
          end else if (take) begin
            rcnt_d = rcnt_q - 3'h1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      rx_st_q <= R_LEAD;
      rkind_q <= K_DATA;
      rcnt_q  <= 3'h0;
      rsum_q  <= 8'h00;
      rerr_q  <= 8'h00;
      rnib_q  <= 4'h0;
      rbad_q  <= 1'b0;
      rdd_q   <= 8'h00;
      rdv_q   <= 1'b0;
      rend_q  <= 1'b0;
    end else begin
      rx_st_q <= rx_st_d;
      rkind_q <= rkind_d;
      rcnt_q  <= rcnt_d;
      rsum_q  <= rsum_d;
      rerr_q  <= rerr_d;
      rnib_q  <= rnib_d;
      rbad_q  <= rbad_d;
      rdd_q   <= rdd_d;
      rdv_q   <= rdv_d;
      rend_q  <= rend_d;
    end
  end

  // All user outputs are flops
  assign TX_DATA_O  = txd_q;
  assign TX_VALID_O = txv_q;
  assign RD_DATA_O  = rdd_q;
  assign RD_VALID_O = rdv_q;
  assign BUSY_O     = busy_q;
  assign DONE_O     = done_q;
  assign RESULT_O   = res_q;
  assign ERR_CODE_O = err_q;
endmodule : dedicated_protocol_framer
`default_nettype wire

// [src/dp_framer_map.svh]
// Purpose: Code points, field constants and timing counts of the framer
// Assumes: 50 MHz reference clock
// Notes:   Definitions only, no logic
`ifndef DP_FRAMER_MAP_SVH
`define DP_FRAMER_MAP_SVH

// Single-byte control codes
`define NUL_CODE        8'h00
`define STX_CODE        8'h02
`define ETX_CODE        8'h03
`define EOT_CODE        8'h04
`define ENQ_CODE        8'h05
`define ACK_CODE        8'h06
`define LF_CODE         8'h0a
`define CLEAR_SEQ_CODE  8'h0c
`define CR_CODE         8'h0d
`define NAK_CODE        8'h15
`define GOOD_CODE       8'h47
`define NO_GOOD_CODE    8'h4e

// Fixed field values
`define STATION_NUMBER  8'h00
`define SELF_CPU_NUMBER 8'hff
`define MASTER_CPU_NUM  8'h00
`define MAX_CPU_NUMBER  8'h40

// Header and tail step numbers
`define HEAD_LAST_STEP  4'h9
`define TAIL_LAST_STEP  4'h4

// Timing
`define CLK_HZ          50000000
`define RESP_TIMEOUT_MS 500
`define RESP_TIMEOUT_CYC ((`CLK_HZ / 1000) * `RESP_TIMEOUT_MS)

`endif

// [src/dp_framer_pkg.sv]
// Purpose: Types and ASCII hex helpers of the framer
// Assumes: Header dp_framer_map.svh holds the numbers
// Notes:   Shared by the framer and its bench
package dp_framer_pkg;

  typedef enum logic [1:0] {
    FMT1 = 2'h0,
    FMT2 = 2'h1,
    FMT3 = 2'h2,
    FMT4 = 2'h3
  } fmt_t;

  // Gray path: idle, head, area, tail, wait for reply
  typedef enum logic [2:0] {
    T_IDLE   = 3'h0,
    T_HEAD   = 3'h1,
    T_AREA   = 3'h3,
    T_TAIL   = 3'h2,
    T_WAITRX = 3'h6
  } tx_state_t;

  typedef enum logic [2:0] {
    R_LEAD = 3'h0,
    R_HEAD = 3'h1,
    R_BODY = 3'h3,
    R_ERR  = 3'h2,
    R_SUM  = 3'h6,
    R_TERM = 3'h4
  } rx_state_t;

  typedef enum logic [2:0] {
    K_ENQ  = 3'h0,
    K_ACK  = 3'h1,
    K_NAK  = 3'h2,
    K_CLR  = 3'h3,
    K_DATA = 3'h4
  } frame_kind_t;

  typedef enum logic [2:0] {
    RES_OK      = 3'h0,
    RES_NAK     = 3'h1,
    RES_SUMERR  = 3'h2,
    RES_TIMEOUT = 3'h3,
    RES_CLEARED = 3'h4
  } result_t;

  function automatic logic [7:0] hex_char(input logic [3:0] n);
    hex_char = (n < 4'ha) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
  endfunction : hex_char

  function automatic logic hex_ok(input logic [7:0] c);
    hex_ok = (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h46);
  endfunction : hex_ok

  function automatic logic [3:0] hex_val(input logic [7:0] c);
    hex_val = (c <= 8'h39) ? c[3:0] : 4'(c[3:0] + 4'h9);
  endfunction : hex_val

endpackage : dp_framer_pkg

// [src/dp_area_fifo.sv]
// Purpose: Buffer for outgoing character-area bytes
// Assumes: One clock, synchronous active-high reset
// Notes:   Input ready is registered so the top output is a flop
`timescale 1ns/1ps
`default_nettype none
module dp_area_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             clk_i,
  input  wire logic             srst_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic      [WIDTH-1:0] out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);
  localparam int unsigned AW = $clog2(DEPTH);
  localparam int unsigned CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
  logic [CW-1:0]    cnt_q, cnt_d;
  logic             rdy_q, rdy_d;
  logic             push, pop;

  // Pointer and count updates; ready looks one word ahead
  always_comb begin
    push  = in_valid_i && rdy_q;
    pop   = out_valid_o && out_ready_i;
    wr_d  = push ? AW'((wr_q + 1'b1) % DEPTH) : wr_q;
    rd_d  = pop ? AW'((rd_q + 1'b1) % DEPTH) : rd_q;
    cnt_d = CW'(cnt_q + {{(CW-1){1'b0}}, push} - {{(CW-1){1'b0}}, pop});
    rdy_d = (cnt_d < CW'(DEPTH));
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
      rdy_q <= 1'b0;
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
      rdy_q <= rdy_d;
    end
  end

  // Storage has no reset; only written words are ever read
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_q] <= in_data_i;
    end
  end

  assign in_ready_o  = rdy_q;
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o  = mem[rd_q];
endmodule : dp_area_fifo
`default_nettype wire

// [tb/dp_framer_assertions.sv]
// Purpose: Port checks of the framer
// Assumes: Synchronous active-high reset
// Notes:   Bound to the top module
`timescale 1ns/1ps
`default_nettype none
module dp_framer_checker (
  input wire logic       REF_CLK_I,
  input wire logic       SRST_I,
  input wire logic       REQ_I,
  input wire logic       TX_READY_I,
  input wire logic [7:0] RX_DATA_I,
  input wire logic       RX_VALID_I,
  input wire logic       TX_VALID_O,
  input wire logic [7:0] TX_DATA_O,
  input wire logic       RD_VALID_O,
  input wire logic       BUSY_O,
  input wire logic       DONE_O,
  input wire logic [2:0] RESULT_O,
  input wire logic       AREA_READY_O
);
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (SRST_I);
  // Quiet line right after reset
  chk_reset_quiet: assert property ($fell(SRST_I) |-> !TX_VALID_O && !BUSY_O)
    else $error("outputs active after reset");
  chk_tx_hold: assert property (TX_VALID_O && !TX_READY_I |=> TX_VALID_O && $stable(TX_DATA_O))
    else $error("tx byte dropped before taken");
  chk_done_end: assert property (DONE_O |-> !BUSY_O && $past(BUSY_O))
    else $error("done without exchange");
  chk_req_taken: assert property (!BUSY_O && REQ_I |=> BUSY_O)
    else $error("request not taken");
  chk_nul_drop: assert property (RX_VALID_I && RX_DATA_I == 8'h00 |=> !RD_VALID_O)
    else $error("null byte forwarded");
  chk_done_pulse: assert property (DONE_O |=> !DONE_O)
    else $error("done longer than a cycle");
  chk_tx_idle: assert property (!BUSY_O |-> !TX_VALID_O)
    else $error("tx while idle");
  chk_rd_idle: assert property (!BUSY_O |-> !RD_VALID_O)
    else $error("reply data while idle");
  // Main endings and a full buffer
  cov_ok: cover property (DONE_O && RESULT_O == 3'h0);
  cov_nak: cover property (DONE_O && RESULT_O == 3'h1);
  cov_clear: cover property (DONE_O && RESULT_O == 3'h4);
  cov_full: cover property (!AREA_READY_O);
endmodule : dp_framer_checker
bind dedicated_protocol_framer dp_framer_checker u_chk (.REF_CLK_I, .SRST_I,
  .REQ_I, .TX_READY_I, .RX_DATA_I, .RX_VALID_I, .TX_VALID_O, .TX_DATA_O,
  .RD_VALID_O, .BUSY_O, .DONE_O, .RESULT_O, .AREA_READY_O);
`default_nettype wire

// [tb/dp_device_model.sv]
// Purpose: Behavioural device on the serial side
// Assumes: One reply per frame of len_i bytes
// Notes:   Mode 0 ack, 1 refusal, 2 silent, 3 data
`timescale 1ns/1ps
`default_nettype none
module dp_device_model (
  input  wire logic       clk_i,
  input  wire logic       srst_i,
  input  wire logic [7:0] tx_data_i,
  input  wire logic       tx_valid_i,
  output logic            tx_ready_o,
  output logic      [7:0] rx_data_o,
  output logic            rx_valid_o,
  input  wire logic       stall_i,
  input  wire logic [1:0] mode_i,
  input  wire logic [7:0] len_i,
  input  wire logic [7:0] err_i
);
  logic [7:0] q[$];
  int         cnt = 0;
  int         gap = 0;
  logic [7:0] nxt;
  logic       v;
  function automatic logic [7:0] asc(input logic [3:0] n);
    return n > 4'h9 ? 8'h37 + n : 8'h30 + n;
  endfunction : asc
  // Idle line toggles so no stale byte looks valid
  always @(posedge clk_i) begin
    v = 1'b0;
    nxt = srst_i ? 8'h00 : ~rx_data_o;
    tx_ready_o <= !stall_i;
    if (srst_i) begin
      cnt = 0;
      q.delete();
    end else if (tx_valid_i && tx_ready_o) begin
      cnt = (tx_data_i == 8'h05) ? 1 : cnt + 1;
      if (tx_data_i inside {8'h04, 8'h15}) q.delete();
      if (cnt == int'(len_i)) begin
        cnt = 0;
        gap = 8; // Message wait before reply
        if (mode_i == 2'h0)
          q = '{8'h06, 8'h30, 8'h00, 8'h30, 8'h46, 8'h46};
        else if (mode_i == 2'h1) // Refusal
          q = '{8'h15, 8'h30, 8'h30, 8'h30, 8'h30,
                asc(err_i[7:4]), asc(err_i[3:0])};
        else if (mode_i == 2'h3)
          q = '{8'h02, 8'h30, 8'h30, 8'h46, 8'h46, asc(err_i[7:4]), 8'h00,
                asc(err_i[3:0]), 8'h03};
        // Silent mode answers nothing
      end
    end else if (gap > 0) gap--;
    else if (q.size() > 0) begin
      v = 1'b1;
      nxt = q.pop_front();
    end
    rx_valid_o <= v;
    rx_data_o <= nxt;
  end
endmodule : dp_device_model
`default_nettype wire

// [tb/dedicated_protocol_framer_tb.sv]
// Purpose: Self-checking bench of the framer
// Assumes: Format one, short reply timeout
// Notes:   Expected bytes and endings kept in queues
`timescale 1ns/1ps
`default_nettype none
module dedicated_protocol_framer_tb
  import dp_framer_pkg::*;
;
  logic        clk = 1'b0, rst = 1'b1, req = 1'b0, clr = 1'b0;
  logic        stall = 1'b0, sum_en = 1'b0, a_vld = 1'b0;
  logic [7:0]  cpu = 8'hff, a_dat = 8'h41, len = 8'h00, err = 8'h00;
  logic [7:0]  flen = 8'h00, nlen = 8'h00, eexp = 8'h00;
  logic [15:0] cmd = 16'h4252;
  logic [3:0]  wt = 4'h3;
  logic [1:0]  mode = 2'h0;
  logic [7:0]  txd, rxd, rdd, ecode;
  logic        txv, txr, rxv, rdv, busy, done, aready;
  logic [2:0]  res;
  logic [31:0] seed = 32'h1179;
  logic [7:0]  exp_tx[$], exp_rd[$];
  logic [10:0] exp_res[$];
  int          error_cnt = 0, total_checks = 0;
  always #10 clk = ~clk;
  dedicated_protocol_framer #(.RESP_TIMEOUT_CYC(200)) DUT (
    .REF_CLK_I(clk), .SRST_I(rst), .FORMAT_I(2'h0), .SUMCHK_EN_I(sum_en),
    .BLOCK_NO_I(8'h00), .TARGET_CPU_I(cpu), .CMD_I(cmd), .WAIT_I(wt),
    .AREA_LEN_I(len), .REQ_I(req), .CLEAR_I(clr), .AREA_DATA_I(a_dat),
    .AREA_VALID_I(a_vld), .AREA_READY_O(aready), .TX_DATA_O(txd),
    .TX_VALID_O(txv), .TX_READY_I(txr), .RX_DATA_I(rxd), .RX_VALID_I(rxv),
    .RD_DATA_O(rdd), .RD_VALID_O(rdv), .BUSY_O(busy), .DONE_O(done),
    .RESULT_O(res), .ERR_CODE_O(ecode));
  dp_device_model u_dev (.clk_i(clk), .srst_i(rst), .tx_data_i(txd),
    .tx_valid_i(txv), .tx_ready_o(txr), .rx_data_o(rxd), .rx_valid_o(rxv),
    .stall_i(stall), .mode_i(mode), .len_i(flen), .err_i(err));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  function automatic logic [7:0] h2a(input logic [3:0] n);
    return n > 4'h9 ? 8'h37 + n : 8'h30 + n;
  endfunction : h2a
  task automatic check(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask : check
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  // Random stalls on the serial side
  always @(posedge clk) begin
    seed <= xs(seed);
    stall <= seed[1] & seed[0];
  end
  // Oldest note against each byte taken and each ending
  always @(posedge clk) begin
    if (txv && txr) begin
      check(exp_tx.size() > 0 && txd === exp_tx[0], "tx byte");
      if (exp_tx.size() > 0) void'(exp_tx.pop_front());
    end
    if (rdv) begin
      check(exp_rd.size() > 0 && rdd === exp_rd[0], "rd byte");
      if (exp_rd.size() > 0) void'(exp_rd.pop_front());
    end
    if (done) begin
      check(exp_res.size() > 0 && {ecode, res} === exp_res[0], "end");
      if (exp_res.size() > 0) void'(exp_res.pop_front());
    end
  end
  // Note one host frame with its ending, then start it
  task automatic frame(input result_t r, input int n, input logic c);
    logic [7:0] f[$];
    logic [7:0] s;
    @(posedge clk);
    f = '{c ? 8'h04 : 8'h05, 8'h30, 8'h30, h2a(cpu[7:4]), h2a(cpu[3:0])};
    if (!c) f = {f, cmd[15:8], cmd[7:0], h2a(wt)};
    for (int i = 0; i < n; i++) f.push_back(8'(8'h41 + i));
    s = 8'h00;
    foreach (f[i]) if (i > 0) s += f[i];
    if (sum_en && !c) f = {f, h2a(s[7:4]), h2a(s[3:0])};
    if (r == RES_TIMEOUT) f = {f, 8'h04, 8'h30, 8'h30, h2a(cpu[7:4]),
                               h2a(cpu[3:0])};
    if (r == RES_NAK) eexp = err;
    flen <= 8'(f.size());
    len <= 8'(n);
    if (mode == 2'h3) begin
      f = {f, 8'h06, 8'h30, 8'h30, h2a(cpu[7:4]), h2a(cpu[3:0])};
      exp_rd = {h2a(err[7:4]), h2a(err[3:0])};
    end
    exp_tx = {exp_tx, f};
    exp_res.push_back({eexp, r});
    if (c) clr <= 1'b1;
    else req <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    req <= 1'b0;
    repeat (3000) if (exp_res.size() > 0) @(posedge clk);
    check(exp_res.size() == 0 && exp_tx.size() == 0, "no end");
    check(exp_rd.size() == 0, "rd left");
    $display("test with result %0d done at %0t", r, $time);
  endtask : frame
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // Fill the area buffer until it refuses
    a_vld <= 1'b1;
    repeat (24) begin
      @(posedge clk);
      if (a_vld && aready) begin
        nlen++;
        a_dat <= 8'h41 + nlen;
      end
    end
    a_vld <= 1'b0;
    check(nlen === 8'd16, "buffer depth");
    frame(RES_OK, 16, 1'b0);
    mode <= 2'h3;
    err <= seed[11:4];
    frame(RES_OK, 0, 1'b0);
    mode <= 2'h1;
    cpu <= 8'h00;
    sum_en <= 1'b1;
    cmd <= 16'h5757;
    wt <= seed[3:0];
    err <= seed[11:4];
    frame(RES_NAK, 0, 1'b0);
    mode <= 2'h2;
    cpu <= 8'hff;
    frame(RES_TIMEOUT, 0, 1'b0);
    frame(RES_CLEARED, 0, 1'b1);
    report_and_stop();
  end
  // Watchdog against a hang
  initial begin
    #400000;
    error_cnt++;
    report_and_stop();
  end
endmodule : dedicated_protocol_framer_tb
`default_nettype wire
